/* design/arpwm_pkg.sv */
/*
 Shared constants, register indices, field positions and bus carriers
 for the auto-reload PWM and capture timer.
 Assumes an APB master with 32-bit data and word-aligned accesses.
*/
package arpwm_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int CH_N = 4;
   localparam int CAP_N = 2;
   localparam int PRESC_W = 7;
   localparam int IDX_W = ADDR_W - 2;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_DUTY3 = 8'h73;
   localparam logic [IDX_W-1:0] IDX_DUTY2 = 8'h74;
   localparam logic [IDX_W-1:0] IDX_DUTY1 = 8'h75;
   localparam logic [IDX_W-1:0] IDX_DUTY0 = 8'h76;
   localparam logic [IDX_W-1:0] IDX_OUT_CTRL = 8'h77;
   localparam logic [IDX_W-1:0] IDX_TIMER_CS = 8'h78;
   localparam logic [IDX_W-1:0] IDX_CNT_ACCESS = 8'h79;
   localparam logic [IDX_W-1:0] IDX_RELOAD = 8'h7a;
   localparam logic [IDX_W-1:0] IDX_CAP_CS = 8'h7b;
   localparam logic [IDX_W-1:0] IDX_CAP_DATA1 = 8'h7c;
   localparam logic [IDX_W-1:0] IDX_CAP_DATA2 = 8'h7d;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'h7e;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h7f;

   // Output control fields
   localparam int OC_EN_LSB = 4;
   localparam int OC_POL_LSB = 0;
   // Timer control/status fields
   localparam int CS_EXT = 7;
   localparam int CS_CC_LSB = 4;
   localparam int CS_CC_W = 3;
   localparam int CS_RUN = 3;
   localparam int CS_FRL = 2;
   localparam int CS_OIE = 1;
   localparam int CS_OVF = 0;
   // Capture control/status fields
   localparam int CC_EDGE_LSB = 4;
   localparam int CC_IE_LSB = 2;
   localparam int CC_FLAG_LSB = 0;
   // Interrupt status and mask fields
   localparam int IRQ_OVF = 0;
   localparam int IRQ_CAP_LSB = 1;
   localparam int IRQ_W = 3;

   localparam logic [REG_W-1:0] REG_RESET = 8'h00;
   localparam logic [REG_W-1:0] CNT_TOP = 8'hff;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } arpwm_apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [DATA_W-1:0] prdata;
   } arpwm_apb_rsp_s;

   typedef enum logic {
      BUS_SETUP = 1'b0,
      BUS_ACCESS = 1'b1
   } arpwm_bus_e;
endpackage

/* design/arpwm_channel.sv */
/*
 One PWM output channel: compare register, polarity and pin mux.
 Assumes reload is a one-cycle pulse on each counter reload.
*/
`timescale 1ns/1ns
module arpwm_channel #(
   parameter int W = 8
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic reload,
   input wire logic [W-1:0] counter,
   input wire logic [W-1:0] duty_value,
   input wire logic pwm_polarity,
   input wire logic enable,
   input wire logic port_level,
   output logic pin,
   output logic oe
);
   logic [W-1:0] channel_compare;
   logic level;

   // Compare takes the duty value at the common first edge
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         channel_compare <= '0;
      end else if (ce && reload) begin
         channel_compare <= duty_value;
      end
   end

   // Polarity acts at once, not at the next reload
   assign level = (counter <= channel_compare) ^ pwm_polarity;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pin <= 1'b0;
         oe <= 1'b0;
      end else if (ce) begin
         pin <= enable ? level : port_level;
         oe <= enable;
      end
   end
endmodule

/* design/arpwm_capture.sv */
/*
 One input capture channel: edge detection and counter latch.
 Assumes the capture input is synchronous to mclk.
*/
`timescale 1ns/1ns
module arpwm_capture #(
   parameter int W = 8
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic cap_in,
   input wire logic rising_sel,
   input wire logic [W-1:0] counter,
   output logic event_pulse,
   output logic [W-1:0] captured_count
);
   logic prev;
   logic primed;
   logic hit;

   // Falling edge when select is zero, rising when one
   assign hit = primed && (rising_sel ? (cap_in && !prev)
                                      : (!cap_in && prev));

   // First cycle after reset only learns the input level
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prev <= 1'b0;
         primed <= 1'b0;
      end else if (ce) begin
         prev <= cap_in;
         primed <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         captured_count <= '0;
         event_pulse <= 1'b0;
      end else if (ce) begin
         event_pulse <= hit;
         if (hit) begin
            captured_count <= counter;
         end
      end
   end
endmodule

/* design/arpwm_top.sv */
/*
 Auto-reload 8-bit timer with four PWM outputs and two input captures,
 reached over an APB slave port with registers at four times their index.
 Assumes pins are synchronous to mclk and a pin mux outside uses pwm_oe.
*/
//
// Behaviour
// - Bits 7:4 of output control enable each PWM channel onto its pin.
// - A polarity change inverts the output at once, not at reload.
// - Each duty register feeds its compare; the first edge is at reload.
// - Bits 7:6 of capture control/status always read zero.
// - Capture edge select zero means falling edge, one means rising.
// - Each capture channel has its own interrupt enable bit.
// - A capture sets its flag; reading its data register clears it.
// - A capture copies the counter into read-only capture data.
// - Registers decode at consecutive indices 73h to 7Fh in listed order.
// - Overflow sets a flag, cleared by reading control/status, with irq.
// - On overflow the reload value is loaded and outputs are updated.
// - A three-bit field divides the input clock by 1 up to 128.
// - Force reload loads the counter, clears the prescaler, reads zero.
`timescale 1ns/1ns
module arpwm_top #(
   parameter int W = arpwm_pkg::REG_W,
   parameter int CH_N = arpwm_pkg::CH_N,
   parameter int CAP_N = arpwm_pkg::CAP_N
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   input wire arpwm_pkg::arpwm_apb_req_s apb_req,
   output arpwm_pkg::arpwm_apb_rsp_s apb_rsp,
   input wire logic ext_clk_in,
   input wire logic [CAP_N-1:0] capture_in,
   input wire logic [CH_N-1:0] port_level,
   output logic [CH_N-1:0] pwm_output,
   output logic [CH_N-1:0] pwm_oe,
   output logic overflow_irq,
   output logic [CAP_N-1:0] capture_irq,
   output logic irq
);
   import arpwm_pkg::*;

   arpwm_bus_e bus_state;
   logic [W-1:0] duty_reg [CH_N];
   logic [W-1:0] output_control_reg;
   logic ext_clock_select;
   logic [CS_CC_W-1:0] prescale_select;
   logic counter_run;
   logic overflow_irq_enable;
   logic overflow_flag;
   logic [W-1:0] counter;
   logic [W-1:0] reload_value_reg;
   logic [CAP_N-1:0] capture_edge;
   logic [CAP_N-1:0] capture_irq_enable;
   logic [CAP_N-1:0] capture_flag;
   logic [CAP_N-1:0] cap_event;
   logic [W-1:0] capture_data_reg [CAP_N];
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [PRESC_W-1:0] prescaler;
   logic [PRESC_W-1:0] presc_mask;
   logic ext_prev;
   logic input_tick;
   logic count_tick;
   logic ovf_evt;
   logic force_reload;
   logic reload_evt;
   logic [IDX_W-1:0] idx;
   logic done;
   logic wr_en;
   logic rd_en;
   logic [W-1:0] wbyte;
   logic [W-1:0] next_rdata;
   logic next_err;

   // Bus decode
   assign idx = apb_req.paddr[ADDR_W-1:2];
   assign done = ce && apb_req.psel && apb_req.penable && apb_rsp.pready;
   assign wr_en = done && apb_req.pwrite && !apb_rsp.pslverr;
   assign rd_en = done && !apb_req.pwrite && !apb_rsp.pslverr;
   assign wbyte = apb_req.pwdata[W-1:0];

   assign force_reload = wr_en && (idx == IDX_TIMER_CS) &&
                         wbyte[CS_FRL];

   // Prescaler and counter clocking
   assign presc_mask = PRESC_W'((8'h01 << prescale_select) - 8'h01);
   assign input_tick = counter_run &&
                       (ext_clock_select ? (ext_clk_in && !ext_prev)
                                         : 1'b1);
   assign count_tick = input_tick &&
                       ((prescaler & presc_mask) == presc_mask);
   assign ovf_evt = count_tick && (counter == CNT_TOP);
   assign reload_evt = ovf_evt || force_reload;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ext_prev <= 1'b0;
      end else if (ce) begin
         ext_prev <= ext_clk_in;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prescaler <= '0;
      end else if (ce) begin
         if (force_reload) begin
            prescaler <= '0;
         end else if (count_tick) begin
            prescaler <= '0;
         end else if (input_tick) begin
            prescaler <= prescaler + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         counter <= REG_RESET;
      end else if (ce) begin
         if (force_reload) begin
            counter <= reload_value_reg;
         end else if (wr_en && idx == IDX_CNT_ACCESS) begin
            counter <= wbyte;
         end else if (ovf_evt) begin
            counter <= reload_value_reg;
         end else if (count_tick) begin
            counter <= counter + 1'b1;
         end
      end
   end

   // Software-written configuration
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < CH_N; i++) begin
            duty_reg[i] <= REG_RESET;
         end
         output_control_reg <= REG_RESET;
         reload_value_reg <= REG_RESET;
      end else if (wr_en) begin
         if (idx == IDX_DUTY3) begin
            duty_reg[3] <= wbyte;
         end else if (idx == IDX_DUTY2) begin
            duty_reg[2] <= wbyte;
         end else if (idx == IDX_DUTY1) begin
            duty_reg[1] <= wbyte;
         end else if (idx == IDX_DUTY0) begin
            duty_reg[0] <= wbyte;
         end else if (idx == IDX_OUT_CTRL) begin
            output_control_reg <= wbyte;
         end else if (idx == IDX_RELOAD) begin
            reload_value_reg <= wbyte;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ext_clock_select <= 1'b0;
         prescale_select <= '0;
         counter_run <= 1'b0;
         overflow_irq_enable <= 1'b0;
      end else if (wr_en && idx == IDX_TIMER_CS) begin
         ext_clock_select <= wbyte[CS_EXT];
         prescale_select <= wbyte[CS_CC_LSB +: CS_CC_W];
         counter_run <= wbyte[CS_RUN];
         overflow_irq_enable <= wbyte[CS_OIE];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         capture_edge <= '0;
         capture_irq_enable <= '0;
      end else if (wr_en && idx == IDX_CAP_CS) begin
         capture_edge <= wbyte[CC_EDGE_LSB +: CAP_N];
         capture_irq_enable <= wbyte[CC_IE_LSB +: CAP_N];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq_mask <= '0;
      end else if (wr_en && idx == IDX_IRQ_MASK) begin
         irq_mask <= wbyte[IRQ_W-1:0];
      end
   end

   // Flags: a set in the clearing cycle wins
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         overflow_flag <= 1'b0;
      end else if (ce) begin
         if (ovf_evt) begin
            overflow_flag <= 1'b1;
         end else if (rd_en && idx == IDX_TIMER_CS) begin
            overflow_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         capture_flag <= '0;
      end else if (ce) begin
         for (int c = 0; c < CAP_N; c++) begin
            if (cap_event[c]) begin
               capture_flag[c] <= 1'b1;
            end else if (rd_en && idx == IDX_CAP_DATA1 + IDX_W'(c)) begin
               capture_flag[c] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status <= '0;
      end else if (ce) begin
         if (wr_en && idx == IDX_IRQ_STATUS) begin
            irq_status <= (irq_status & ~wbyte[IRQ_W-1:0]) |
                          {cap_event, ovf_evt};
         end else begin
            irq_status <= irq_status | {cap_event, ovf_evt};
         end
      end
   end

   // Interrupt outputs
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         overflow_irq <= 1'b0;
         capture_irq <= '0;
         irq <= 1'b0;
      end else if (ce) begin
         overflow_irq <= overflow_flag && overflow_irq_enable;
         capture_irq <= capture_flag & capture_irq_enable;
         irq <= |(irq_status & irq_mask);
      end
   end

   // Read data mux
   always_comb begin
      next_rdata = REG_RESET;
      next_err = 1'b0;
      if (idx == IDX_DUTY3) begin
         next_rdata = duty_reg[3];
      end else if (idx == IDX_DUTY2) begin
         next_rdata = duty_reg[2];
      end else if (idx == IDX_DUTY1) begin
         next_rdata = duty_reg[1];
      end else if (idx == IDX_DUTY0) begin
         next_rdata = duty_reg[0];
      end else if (idx == IDX_OUT_CTRL) begin
         next_rdata = output_control_reg;
      end else if (idx == IDX_TIMER_CS) begin
         next_rdata[CS_EXT] = ext_clock_select;
         next_rdata[CS_CC_LSB +: CS_CC_W] = prescale_select;
         next_rdata[CS_RUN] = counter_run;
         next_rdata[CS_FRL] = 1'b0;
         next_rdata[CS_OIE] = overflow_irq_enable;
         next_rdata[CS_OVF] = overflow_flag;
      end else if (idx == IDX_CNT_ACCESS) begin
         next_rdata = counter;
      end else if (idx == IDX_RELOAD) begin
         next_rdata = reload_value_reg;
      end else if (idx == IDX_CAP_CS) begin
         // Top bits stay zero
         next_rdata[CC_EDGE_LSB +: CAP_N] = capture_edge;
         next_rdata[CC_IE_LSB +: CAP_N] = capture_irq_enable;
         next_rdata[CC_FLAG_LSB +: CAP_N] = capture_flag;
      end else if (idx == IDX_CAP_DATA1) begin
         next_rdata = capture_data_reg[0];
      end else if (idx == IDX_CAP_DATA2) begin
         next_rdata = capture_data_reg[1];
      end else if (idx == IDX_IRQ_STATUS) begin
         next_rdata[IRQ_W-1:0] = irq_status;
      end else if (idx == IDX_IRQ_MASK) begin
         next_rdata[IRQ_W-1:0] = irq_mask;
      end else begin
         next_err = 1'b1;
      end
   end

   // APB answer: ready in the first access cycle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         bus_state <= BUS_SETUP;
         apb_rsp <= '0;
      end else if (ce) begin
         case (bus_state)
            BUS_SETUP: begin
               if (apb_req.psel && !apb_req.penable) begin
                  bus_state <= BUS_ACCESS;
                  apb_rsp.pready <= 1'b1;
                  apb_rsp.pslverr <= next_err;
                  apb_rsp.prdata <= apb_req.pwrite ? '0
                                    : DATA_W'(next_rdata);
               end
            end
            BUS_ACCESS: begin
               bus_state <= BUS_SETUP;
               apb_rsp <= '0;
            end
            default: begin
               bus_state <= BUS_SETUP;
            end
         endcase
      end
   end

   // PWM channels
   for (genvar g = 0; g < CH_N; g++) begin : g_pwm
      arpwm_channel #(
         .W(W)
      ) u_channel (
         .mclk(mclk),
         .reset_n(reset_n),
         .ce(ce),
         .reload(reload_evt),
         .counter(counter),
         .duty_value(duty_reg[g]),
         .pwm_polarity(output_control_reg[OC_POL_LSB + g]),
         .enable(output_control_reg[OC_EN_LSB + g]),
         .port_level(port_level[g]),
         .pin(pwm_output[g]),
         .oe(pwm_oe[g])
      );
   end

   // Capture channels
   for (genvar g = 0; g < CAP_N; g++) begin : g_cap
      arpwm_capture #(
         .W(W)
      ) u_capture (
         .mclk(mclk),
         .reset_n(reset_n),
         .ce(ce),
         .cap_in(capture_in[g]),
         .rising_sel(capture_edge[g]),
         .counter(counter),
         .event_pulse(cap_event[g]),
         .captured_count(capture_data_reg[g])
      );
   end
endmodule

/* dv/arpwm_monitor.sv */
/*
 Port checker for the PWM and capture timer: bus answer, pin mux and
 interrupt gating. Assumes it is bound to arpwm_top and sees its ports.
*/
`timescale 1ns/1ns
module arpwm_monitor #(
   parameter int W = 8,
   parameter int CH_N = 4,
   parameter int CAP_N = 2
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   input wire arpwm_pkg::arpwm_apb_req_s apb_req,
   input wire arpwm_pkg::arpwm_apb_rsp_s apb_rsp,
   input wire logic ext_clk_in,
   input wire logic [CAP_N-1:0] capture_in,
   input wire logic [CH_N-1:0] port_level,
   input wire logic [CH_N-1:0] pwm_output,
   input wire logic [CH_N-1:0] pwm_oe,
   input wire logic overflow_irq,
   input wire logic [CAP_N-1:0] capture_irq,
   input wire logic irq
);
   import arpwm_pkg::*;
   logic [IDX_W-1:0] idx;
   logic acc, wr, rd;
   logic [7:0] oc_sh;
   logic oie_sh;
   logic [1:0] cie_sh;
   logic [IRQ_W-1:0] mask_sh;
   assign idx = apb_req.paddr[ADDR_W-1:2];
   assign acc = ce && apb_req.psel && apb_req.penable && apb_rsp.pready;
   assign wr = acc && apb_req.pwrite;
   assign rd = acc && !apb_req.pwrite;

   // Shadow of enable and mask bits as software wrote them
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         oc_sh <= 8'h00;
         oie_sh <= 1'b0;
         cie_sh <= 2'b00;
         mask_sh <= '0;
      end else if (wr) begin
         case (idx)
            IDX_OUT_CTRL: oc_sh <= apb_req.pwdata[7:0];
            IDX_TIMER_CS: oie_sh <= apb_req.pwdata[CS_OIE];
            IDX_CAP_CS: cie_sh <= apb_req.pwdata[CC_IE_LSB +: 2];
            IDX_IRQ_MASK: mask_sh <= apb_req.pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);

   AST_SETUP_READY: assert property (
      ce && apb_req.psel && !apb_req.penable
      |=> apb_rsp.pready ##1 !apb_rsp.pready)
      else $error("pready not one cycle after setup");
   AST_DECODE_ERR: assert property (
      apb_rsp.pready |-> apb_rsp.pslverr
         == (idx < IDX_DUTY3 || idx > IDX_IRQ_MASK))
      else $error("pslverr disagrees with address map");
   AST_CAP_RSVD: assert property (
      rd && idx == IDX_CAP_CS |-> apb_rsp.prdata[7:6] == 2'b00)
      else $error("capture status top bits not zero");
   AST_FRL_ZERO: assert property (
      rd && idx == IDX_TIMER_CS |-> !apb_rsp.prdata[CS_FRL])
      else $error("force reload bit read back set");
   AST_OE_FOLLOW: assert property (
      pwm_oe == $past(oc_sh[7:4]))
      else $error("pwm_oe differs from enable bits");
   AST_PORT_PASS: assert property (
      $past(reset_n) |->
         ((pwm_output ^ $past(port_level)) & ~pwm_oe) == '0)
      else $error("disabled pin not at port level");
   AST_OVF_IRQ_EN: assert property (
      overflow_irq |-> $past(oie_sh))
      else $error("overflow irq while disabled");
   AST_CAP_IRQ_EN: assert property (
      (capture_irq & ~$past(cie_sh)) == '0)
      else $error("capture irq while its enable is clear");
   AST_IRQ_MASK: assert property (
      irq |-> $past(mask_sh) != '0)
      else $error("irq with all sources masked");
   AST_CAP_CLEAR: assert property (
      rd && idx == IDX_CAP_DATA1 && capture_in[0] == $past(capture_in[0])
      && capture_in[0] == $past(capture_in[0], 2) |-> ##2 !capture_irq[0])
      else $error("capture irq stays after data read");

   cover property (wr && idx == IDX_OUT_CTRL);
   cover property ($rose(overflow_irq));
   cover property ($rose(capture_irq[0]));
endmodule

bind arpwm_top arpwm_monitor #(.W(W), .CH_N(CH_N), .CAP_N(CAP_N)) u_mon (
   .mclk(mclk), .reset_n(reset_n), .ce(ce), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .ext_clk_in(ext_clk_in), .capture_in(capture_in),
   .port_level(port_level), .pwm_output(pwm_output), .pwm_oe(pwm_oe),
   .overflow_irq(overflow_irq), .capture_irq(capture_irq), .irq(irq)
);

/* dv/arpwm_pins.sv */
/*
 Far-side pin model: capture inputs, ordinary port levels and a slow
 external count clock. Assumes the bench clock on mclk.
*/
`timescale 1ns/1ns
module arpwm_pins (
   input wire logic mclk,
   output logic [1:0] capture_in,
   output logic [3:0] port_level,
   output logic ext_clk_in
);
   logic [1:0] div;
   initial begin
      capture_in = 2'b00;
      port_level = 4'ha;
      ext_clk_in = 1'b0;
      div = 2'b00;
   end
   // Free-running external clock, a quarter of mclk
   always @(posedge mclk) begin
      div <= div + 2'b01;
      ext_clk_in <= div[1];
   end
   task automatic set_cap(input logic [1:0] lvl);
      @(posedge mclk);
      capture_in <= lvl;
   endtask
endmodule

/* dv/arpwm_top_bench.sv */
/*
 Self-checking bench for the timer: register map over APB, PWM pins,
 overflow and capture interrupts. Assumes arpwm_pins on the far side.
*/
`timescale 1ns/1ns
module arpwm_top_bench;
   import arpwm_pkg::*;
   logic mclk, reset_n, ce, ext_clk_in, overflow_irq, irq, err;
   arpwm_apb_req_s req;
   arpwm_apb_rsp_s rsp;
   logic [1:0] capture_in, capture_irq;
   logic [3:0] port_level, pwm_output, pwm_oe;
   logic [31:0] rd;
   int n_errors;
   int compares;

   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   arpwm_top u_dut (
      .mclk(mclk), .reset_n(reset_n), .ce(ce), .apb_req(req),
      .apb_rsp(rsp), .ext_clk_in(ext_clk_in), .capture_in(capture_in),
      .port_level(port_level), .pwm_output(pwm_output), .pwm_oe(pwm_oe),
      .overflow_irq(overflow_irq), .capture_irq(capture_irq), .irq(irq)
   );
   arpwm_pins u_pins (
      .mclk(mclk), .capture_in(capture_in), .port_level(port_level),
      .ext_clk_in(ext_clk_in)
   );

   task automatic finish_test();
      if (n_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [IDX_W-1:0] idx,
                      input logic [31:0] wd);
      int n;
      @(posedge mclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr,
               paddr: {idx, 2'b00}, pwdata: wd};
      @(posedge mclk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      if (n >= 20) begin
         n_errors++;
         finish_test();
      end
   endtask

   task automatic rdchk(input logic [IDX_W-1:0] idx,
                        input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rd, exp);
   endtask

   task automatic settle();
      repeat (4) @(posedge mclk);
      #1;
   endtask

   task automatic t_map();
      for (int i = 'h73; i <= 'h7f; i++) begin
         rdchk(i[7:0], 32'h0);
         chk(32'(err), 32'h0);
      end
      rdchk(8'h72, 32'h0);
      chk(32'(err), 32'h1);
      for (int i = 'h73; i <= 'h77; i++) apb(1'b1, i[7:0], i);
      apb(1'b1, IDX_RELOAD, 32'h5a);
      for (int i = 'h73; i <= 'h77; i++) rdchk(i[7:0], i);
      rdchk(IDX_RELOAD, 32'h5a);
   endtask

   task automatic t_pwm();
      apb(1'b1, IDX_RELOAD, 32'h05);
      apb(1'b1, IDX_DUTY0, 32'h10);
      apb(1'b1, IDX_DUTY1, 32'h05);
      apb(1'b1, IDX_DUTY2, 32'h04);
      apb(1'b1, IDX_DUTY3, 32'h00);
      apb(1'b1, IDX_OUT_CTRL, 32'hf0);
      apb(1'b1, IDX_TIMER_CS, 32'h04);
      settle();
      chk(32'(pwm_output), 32'h3);
      rdchk(IDX_TIMER_CS, 32'h00);
      rdchk(IDX_CNT_ACCESS, 32'h05);
      apb(1'b1, IDX_OUT_CTRL, 32'hff);
      settle();
      chk(32'(pwm_output), 32'hc);
      apb(1'b1, IDX_OUT_CTRL, 32'h5f);
      settle();
      chk(32'(pwm_output), 32'he);
      chk(32'(pwm_oe), 32'h5);
      apb(1'b1, IDX_OUT_CTRL, 32'hf0);
      apb(1'b1, IDX_CNT_ACCESS, 32'h10);
      settle();
      chk(32'(pwm_output), 32'h1);
   endtask

   task automatic t_ovf();
      int n;
      apb(1'b1, IDX_RELOAD, 32'hfe);
      // Run, divide by 4, force reload, overflow irq on
      apb(1'b1, IDX_TIMER_CS, 32'h2e);
      n = 0;
      while (overflow_irq !== 1'b1 && n < 40) begin
         @(posedge mclk);
         n++;
      end
      chk(32'(n >= 8 && n <= 13), 32'h1);
      if (n >= 40) begin
         finish_test();
      end
      apb(1'b1, IDX_TIMER_CS, 32'h02);
      rdchk(IDX_TIMER_CS, 32'h03);
      rdchk(IDX_TIMER_CS, 32'h02);
      settle();
      chk(32'(overflow_irq), 32'h0);
      rdchk(IDX_IRQ_STATUS, 32'h01);
      chk(32'(irq), 32'h0);
      apb(1'b1, IDX_IRQ_MASK, 32'h01);
      settle();
      chk(32'(irq), 32'h1);
      apb(1'b1, IDX_IRQ_STATUS, 32'h01);
      settle();
      chk(32'(irq), 32'h0);
      // External clock, no division: one count per ext rising edge
      apb(1'b1, IDX_CNT_ACCESS, 32'h00);
      apb(1'b1, IDX_TIMER_CS, 32'h88);
      repeat (40) @(posedge mclk);
      apb(1'b1, IDX_TIMER_CS, 32'h00);
      apb(1'b0, IDX_CNT_ACCESS, 32'h0);
      chk(32'(rd >= 32'h9 && rd <= 32'hc), 32'h1);
   endtask

   task automatic t_cap();
      apb(1'b1, IDX_CNT_ACCESS, 32'h33);
      apb(1'b1, IDX_CAP_CS, 32'hdf);
      rdchk(IDX_CAP_CS, 32'h1c);
      u_pins.set_cap(2'b11);
      settle();
      rdchk(IDX_CAP_CS, 32'h1d);
      chk(32'(capture_irq), 32'h1);
      apb(1'b1, IDX_CAP_DATA1, 32'haa);
      rdchk(IDX_CAP_DATA1, 32'h33);
      rdchk(IDX_CAP_CS, 32'h1c);
      apb(1'b1, IDX_CNT_ACCESS, 32'h44);
      u_pins.set_cap(2'b00);
      settle();
      rdchk(IDX_CAP_CS, 32'h1e);
      rdchk(IDX_CAP_DATA2, 32'h44);
      settle();
      chk(32'(capture_irq), 32'h0);
      apb(1'b1, IDX_IRQ_STATUS, 32'h06);
      apb(1'b1, IDX_CAP_CS, 32'h34);
      u_pins.set_cap(2'b11);
      settle();
      chk(32'(capture_irq), 32'h1);
      rdchk(IDX_IRQ_STATUS, 32'h06);
      chk(32'(irq), 32'h0);
      apb(1'b1, IDX_IRQ_MASK, 32'h04);
      settle();
      chk(32'(irq), 32'h1);
   endtask

   initial begin
      reset_n = 1'b0;
      ce = 1'b1;
      req = '0;
      n_errors = 0;
      compares = 0;
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      t_map();
      t_pwm();
      t_ovf();
      t_cap();
      finish_test();
   end
endmodule
